// file: hw/mrb_cfg.svh
// offsets, field positions, reset values and timing of the mode register bank
`ifndef MRB_CFG_SVH
`define MRB_CFG_SVH

// mode register addresses
`define MA_REV 8'h07
`define MA_CFG 8'h08
`define MA_VTEST 8'h09
`define MA_ZQ 8'h0A
`define MA_ODT 8'h0B
`define MA_VREF 8'h0C
`define MA_FSP 8'h0D
`define MA_SE 8'h33

// field positions
`define F_SE_CAP 0
`define F_TYPE_LSB 0
`define F_DENS_LSB 2
`define F_WIDTH_LSB 6
`define F_ZQ_RST 0
`define F_DATA_BUS_TERMINATION_LSB 0
`define F_COMMAND_BUS_TERMINATION_LSB 4
`define F_VREF_RANGE 6
`define F_SETPOINT_ACCESS_SELECT 6
`define F_SETPOINT_ACTIVE_SELECT 7

// masks, codes and reset values
`define ODT_MASK 8'h77
`define VREF_MASK 8'h7F
`define ODT_RST 8'h00
`define VREF_RST 8'h4D
`define VTEST_RST 8'h00
`define TYPE_S16 2'h0
`define WIDTH_X16 2'h0
`define ODT_RSVD 3'h7
`define VREF_BASE_R0 9'h064
`define VREF_BASE_R1 9'h0DC

// timing
`define CLK_NS 20
`define DQ_HOLD_NS 160
`define DQ_HOLD_CYC ((`DQ_HOLD_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// file: hw/mrb_pkg.sv
// types shared by the mode register bank modules
package mrb_pkg;
  typedef struct packed {
    logic wr;
    logic [7:0] ma;
    logic [7:0] op;
  } mr_cmd_s;

  typedef enum logic {DQ_IDLE, DQ_DRIVE} dq_state_e;
endpackage

// file: hw/mr_cmd_if.sv
// decoded mode register command between sampler and bank
`timescale 1ns/1ps
interface mr_cmd_if;
  logic valid;
  mrb_pkg::mr_cmd_s cmd;
  modport src (output valid, output cmd);
  modport dst (input valid, input cmd);
endinterface

// file: hw/link_sampler.sv
// samples the controller's command pins and link clock on clk
`timescale 1ns/1ps
module link_sampler (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // command pins
  input wire logic link_ck,
  input wire logic link_cs,
  input wire logic link_we,
  input wire logic [7:0] link_ma,
  input wire logic [7:0] link_op,
  // decoded command
  mr_cmd_if.src cmd
);
  localparam int N = 19;
  logic [N-1:0] raw;
  logic [N-1:0] s1_r;
  logic [N-1:0] s2_r;
  logic [N-1:0] s3_r;
  logic [N-1:0] filt_r;
  logic ck_prev_r;
  logic valid_r;
  mrb_pkg::mr_cmd_s cmd_r;
  logic agree;

  assign raw = {link_ck, link_cs, link_we, link_ma, link_op};

  ////////////////////////////////////////////////////////////////////////////
  // three flops; s1 feeds only s2
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // a change counts only once two stages agree
  always_ff @(posedge clk) begin
    if (!nrst) begin
      filt_r <= '0;
    end else begin
      filt_r <= (s2_r & ~(s2_r ^ s3_r)) | (filt_r & (s2_r ^ s3_r));
    end
  end

  assign agree = filt_r[N-1] & ~ck_prev_r;

  ////////////////////////////////////////////////////////////////////////////
  // pins must hold from before the rising link edge to its falling edge
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ck_prev_r <= 1'b0;
      valid_r <= 1'b0;
      cmd_r <= '0;
    end else begin
      ck_prev_r <= filt_r[N-1];
      valid_r <= agree & filt_r[N-2];
      cmd_r <= filt_r[N-3:0];
    end
  end

  assign cmd.valid = valid_r;
  assign cmd.cmd = cmd_r;

  a_one_pulse: assert property (@(posedge clk) disable iff (!nrst)
    valid_r |=> !valid_r)
    else $error("command pulse longer than one cycle");
endmodule

// file: hw/setpoint_copy.sv
// one mode register held twice, once per frequency set point
`timescale 1ns/1ps
module setpoint_copy #(
  parameter logic [7:0] RST = 8'h00,
  parameter logic [7:0] MASK = 8'hFF
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // write side
  input wire logic wr_en,
  input wire logic wr_sel,
  input wire logic [7:0] wdata,
  // read and apply
  input wire logic act_sel,
  output logic [7:0] rdata,
  output logic [7:0] act_data
);
  logic [7:0] copy_r [2];

  // only the selected copy changes
  always_ff @(posedge clk) begin
    if (!nrst) begin
      copy_r[0] <= RST;
      copy_r[1] <= RST;
    end else if (wr_en) begin
      copy_r[wr_sel] <= wdata & MASK;
    end
  end

  assign rdata = copy_r[wr_sel];
  assign act_data = copy_r[act_sel];

  a_other_kept: assert property (@(posedge clk) disable iff (!nrst)
    wr_en |=> copy_r[!$past(wr_sel)] == $past(copy_r[!wr_sel]))
    else $error("unselected set point copy changed");
endmodule

// file: hw/dram_mode_register_bank_b.sv
// mode register bank: identity, configuration, termination and reference
`timescale 1ns/1ps
`include "mrb_cfg.svh"

// Overview of operation
// - capability bit 0 reports single-ended support
// - bits 7:1 return fixed revision code
// - config bits 1:0 report prefetch type
// - config bits 5:2 report die density
// - config bits 7:6 report data width
// - calibration bit 0 resets impedance to default
// - grounded calibration pin ignores calibration commands
// - data termination code, zero off, seven reserved
// - command termination same coding, bits 3,7 reserved
// - access select picks copy for writes, reads
// - active select picks applied copy only
// - reference level codes up to 110010; higher codes are kept as written
// - bit 6 picks reference range, one at reset
// - level maps linearly, 0.4 percent per step
// - reference read drives eight bits, reserved zero
// - range and level kept until write or reset
// - single-ended enable only if capability set
// - select bits sit in control bits 6,7
module dram_mode_register_bank_b #(
  parameter logic [6:0] REV_CODE = 7'h2A, // arbitrary value
  parameter logic SE_CAP = 1'b1,
  parameter logic [3:0] DENSITY = 4'h6
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // command pins from the controller
  input wire logic link_ck,
  input wire logic link_cs,
  input wire logic link_we,
  input wire logic [7:0] link_ma,
  input wire logic [7:0] link_op,
  // calibration pin strap, high when tied to ground
  input wire logic zq_to_gnd,
  // read data pins
  output logic [7:0] dq_out,
  output logic dq_oe_n,
  // applied settings
  output logic impedance_default_reset_pulse,
  output logic cal_default,
  output logic [2:0] dq_term,
  output logic [2:0] ca_term,
  output logic [5:0] vref_level,
  output logic vref_range,
  output logic [8:0] vref_tenth_pct,
  output logic setpoint_active,
  output logic single_ended_en
);
  localparam logic [3:0] HOLD = 4'(`DQ_HOLD_CYC);

  mr_cmd_if cmd ();
  logic wr_hit;
  logic rd_hit;
  logic [7:0] rev_val;
  logic [7:0] cfg_val;
  logic [7:0] odt_rd;
  logic [7:0] odt_act;
  logic [7:0] vref_rd;
  logic [7:0] vref_act;
  logic [7:0] rd_val;
  logic [7:0] vtest_r;
  logic setpoint_access_select_r;
  logic setpoint_active_select_r;
  logic zq_s1_r;
  logic zq_s2_r;
  logic zq_s3_r;
  logic zq_filt_r;
  logic [1:0] strap_cnt_r;
  logic strap_taken_r;
  logic zq_gnd_r;
  logic zq_pulse_r;
  logic cal_def_r;
  logic [7:0] dq_out_r;
  logic dq_oe_n_r;
  logic [3:0] hold_r;
  mrb_pkg::dq_state_e dq_st_r;
  logic [2:0] dq_term_r;
  logic [2:0] ca_term_r;
  logic [5:0] vref_level_r;
  logic vref_range_r;
  logic [8:0] vref_pct_r;
  logic se_en_r;

  function automatic logic is_ma(input logic [7:0] ma, input logic [7:0] target);
    is_ma = (ma == target);
  endfunction

  link_sampler u_sampler (
    .clk(clk),
    .nrst(nrst),
    .link_ck(link_ck),
    .link_cs(link_cs),
    .link_we(link_we),
    .link_ma(link_ma),
    .link_op(link_op),
    .cmd(cmd)
  );

  assign wr_hit = cmd.valid & cmd.cmd.wr;
  assign rd_hit = cmd.valid & ~cmd.cmd.wr;

  ////////////////////////////////////////////////////////////////////////////
  // set point copies of termination and reference
  setpoint_copy #(.RST(`ODT_RST), .MASK(`ODT_MASK)) u_odt (
    .clk(clk),
    .nrst(nrst),
    .wr_en(wr_hit & is_ma(cmd.cmd.ma, `MA_ODT)),
    .wr_sel(setpoint_access_select_r),
    .wdata(cmd.cmd.op),
    .act_sel(setpoint_active_select_r),
    .rdata(odt_rd),
    .act_data(odt_act)
  );

  // reset restores range one, level 001101
  setpoint_copy #(.RST(`VREF_RST), .MASK(`VREF_MASK)) u_vref (
    .clk(clk),
    .nrst(nrst),
    .wr_en(wr_hit & is_ma(cmd.cmd.ma, `MA_VREF)),
    .wr_sel(setpoint_access_select_r),
    .wdata(cmd.cmd.op),
    .act_sel(setpoint_active_select_r),
    .rdata(vref_rd),
    .act_data(vref_act)
  );

  ////////////////////////////////////////////////////////////////////////////
  // capability bit and revision code
  assign rev_val = {REV_CODE, SE_CAP};
  // type, density and width, all fixed
  assign cfg_val = {`WIDTH_X16, DENSITY, `TYPE_S16};

  // read mux, unmapped and write-only read zero
  always_comb begin
    rd_val = 8'h00;
    if (is_ma(cmd.cmd.ma, `MA_REV)) begin
      rd_val = rev_val;
    end else if (is_ma(cmd.cmd.ma, `MA_CFG)) begin
      rd_val = cfg_val;
    end else if (is_ma(cmd.cmd.ma, `MA_VTEST)) begin
      rd_val = vtest_r;
    end else if (is_ma(cmd.cmd.ma, `MA_ODT)) begin
      rd_val = odt_rd;
    end else if (is_ma(cmd.cmd.ma, `MA_VREF)) begin
      rd_val = vref_rd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // set point selects; other control bits not held here
  always_ff @(posedge clk) begin
    if (!nrst) begin
      setpoint_access_select_r <= 1'b0;
      setpoint_active_select_r <= 1'b0;
    end else if (wr_hit && is_ma(cmd.cmd.ma, `MA_FSP)) begin
      setpoint_access_select_r <= cmd.cmd.op[`F_SETPOINT_ACCESS_SELECT];
      setpoint_active_select_r <= cmd.cmd.op[`F_SETPOINT_ACTIVE_SELECT];
    end
  end

  // no write path to identity or configuration
  always_ff @(posedge clk) begin
    if (!nrst) begin
      vtest_r <= `VTEST_RST;
    end else if (wr_hit && is_ma(cmd.cmd.ma, `MA_VTEST)) begin
      vtest_r <= cmd.cmd.op;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      se_en_r <= 1'b0;
    end else if (wr_hit && is_ma(cmd.cmd.ma, `MA_SE)) begin
      se_en_r <= SE_CAP & (cmd.cmd.op != 8'h00);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // strap pin synchronised, taken once it has settled
  always_ff @(posedge clk) begin
    if (!nrst) begin
      zq_s1_r <= 1'b0;
      zq_s2_r <= 1'b0;
      zq_s3_r <= 1'b0;
      zq_filt_r <= 1'b0;
    end else begin
      zq_s1_r <= zq_to_gnd;
      zq_s2_r <= zq_s1_r;
      zq_s3_r <= zq_s2_r;
      if (zq_s2_r == zq_s3_r) begin
        zq_filt_r <= zq_s2_r;
      end
    end
  end

  // strap must not change after power-up, so it is sampled once
  always_ff @(posedge clk) begin
    if (!nrst) begin
      strap_cnt_r <= 2'h0;
      strap_taken_r <= 1'b0;
      zq_gnd_r <= 1'b0;
    end else if (!strap_taken_r) begin
      strap_cnt_r <= strap_cnt_r + 2'h1;
      if (strap_cnt_r == 2'h3) begin
        strap_taken_r <= 1'b1;
        // filter output lags a cycle, so take its next value
        zq_gnd_r <= (zq_s2_r == zq_s3_r) ? zq_s2_r : zq_filt_r;
      end
    end
  end

  // calibration reset pulse and default flag
  always_ff @(posedge clk) begin
    if (!nrst) begin
      zq_pulse_r <= 1'b0;
      cal_def_r <= 1'b0;
    end else begin
      zq_pulse_r <= 1'b0;
      // grounded pin: default only, commands dropped
      if (zq_gnd_r) begin
        cal_def_r <= 1'b1;
      end else if (wr_hit && is_ma(cmd.cmd.ma, `MA_ZQ) && cmd.cmd.op[`F_ZQ_RST]) begin
        zq_pulse_r <= 1'b1;
        cal_def_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read drives data pins for one link period
  always_ff @(posedge clk) begin
    if (!nrst) begin
      dq_st_r <= mrb_pkg::DQ_IDLE;
      dq_out_r <= 8'h00;
      dq_oe_n_r <= 1'b1;
      hold_r <= 4'h0;
    end else begin
      case (dq_st_r)
        mrb_pkg::DQ_IDLE: begin
          if (rd_hit) begin
            dq_st_r <= mrb_pkg::DQ_DRIVE;
            dq_out_r <= rd_val;
            dq_oe_n_r <= 1'b0;
            hold_r <= HOLD - 4'h1;
          end
        end
        mrb_pkg::DQ_DRIVE: begin
          if (rd_hit) begin
            dq_out_r <= rd_val;
            hold_r <= HOLD - 4'h1;
          end else if (hold_r == 4'h0) begin
            dq_st_r <= mrb_pkg::DQ_IDLE;
            dq_out_r <= 8'h00;
            dq_oe_n_r <= 1'b1;
          end else begin
            hold_r <= hold_r - 4'h1;
          end
        end
        default: begin
          dq_st_r <= mrb_pkg::DQ_IDLE;
          dq_oe_n_r <= 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // only the active copy reaches the outputs
  always_ff @(posedge clk) begin
    if (!nrst) begin
      dq_term_r <= 3'h0;
      ca_term_r <= 3'h0;
      vref_level_r <= 6'h0D;
      vref_range_r <= 1'b1;
      vref_pct_r <= 9'h110;
    end else begin
      dq_term_r <= (odt_act[2:0] == `ODT_RSVD) ? 3'h0 : odt_act[2:0];
      ca_term_r <= (odt_act[6:4] == `ODT_RSVD) ? 3'h0 : odt_act[6:4];
      // codes above 110010 stored as written
      vref_level_r <= vref_act[5:0];
      vref_range_r <= vref_act[`F_VREF_RANGE];
      // tenths of a percent, four per step
      vref_pct_r <= (vref_act[`F_VREF_RANGE] ? `VREF_BASE_R1 : `VREF_BASE_R0)
        + {1'b0, vref_act[5:0], 2'b00};
    end
  end

  assign dq_out = dq_out_r;
  assign dq_oe_n = dq_oe_n_r;
  assign impedance_default_reset_pulse = zq_pulse_r;
  assign cal_default = cal_def_r;
  assign dq_term = dq_term_r;
  assign ca_term = ca_term_r;
  assign vref_level = vref_level_r;
  assign vref_range = vref_range_r;
  assign vref_tenth_pct = vref_pct_r;
  assign setpoint_active = setpoint_active_select_r;
  assign single_ended_en = se_en_r;

  ////////////////////////////////////////////////////////////////////////////
  default clocking dc @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence read_of(logic [7:0] ma);
    rd_hit && cmd.cmd.ma == ma;
  endsequence

  sequence drive_held;
    !dq_oe_n_r [*8];
  endsequence

  a_rev_cap: assert property (
    read_of(`MA_REV) |=> dq_out_r[0] == SE_CAP)
    else $error("capability bit wrong");

  a_rev_code: assert property (
    read_of(`MA_REV) |=> dq_out_r[7:1] == REV_CODE)
    else $error("revision code wrong");

  a_cfg_type: assert property (
    read_of(`MA_CFG) |=> dq_out_r[1:0] == 2'h0)
    else $error("memory type wrong");

  a_cfg_density: assert property (
    read_of(`MA_CFG) |=> dq_out_r[5:2] == DENSITY)
    else $error("density wrong");

  a_cfg_width: assert property (
    read_of(`MA_CFG) |=> dq_out_r[7:6] == 2'h0)
    else $error("width wrong");

  a_impedance_default_reset: assert property (
    wr_hit && cmd.cmd.ma == `MA_ZQ && cmd.cmd.op[0] && !zq_gnd_r
    |=> zq_pulse_r ##1 !zq_pulse_r)
    else $error("calibration reset pulse missing");

  a_zq_ignored: assert property (
    zq_gnd_r |=> !zq_pulse_r && cal_def_r)
    else $error("calibration command not ignored");

  a_term_rsvd: assert property (
    dq_term_r != 3'h7 && ca_term_r != 3'h7)
    else $error("reserved termination applied");

  a_inactive_write: assert property (
    wr_hit && cmd.cmd.ma == `MA_VREF && setpoint_access_select_r != setpoint_active_select_r
    |=> ##1 $stable(vref_level_r) && $stable(vref_range_r))
    else $error("inactive copy write disturbed level");

  a_vref_read: assert property (
    read_of(`MA_VREF) |=> dq_out_r[7] == 1'b0 ##0 drive_held)
    else $error("reference read not driven or reserved bit set");

  a_fsp_select: assert property (
    wr_hit && cmd.cmd.ma == `MA_FSP
    |=> setpoint_access_select_r == $past(cmd.cmd.op[6]) && setpoint_active_select_r == $past(cmd.cmd.op[7]))
    else $error("set point select not taken");

  a_se_refused: assert property (
    wr_hit && cmd.cmd.ma == `MA_SE
    |=> se_en_r == (SE_CAP && $past(cmd.cmd.op) != 8'h00))
    else $error("single-ended enabled without capability");
endmodule

// file: dv/mr_ctrl_model.sv
// memory controller model issuing mode register commands
`timescale 1ns/1ps
`include "mrb_cfg.svh"
module mr_ctrl_model (
  // clock
  input wire logic clk,
  // command pins
  output logic link_ck,
  output logic link_cs,
  output logic link_we,
  output logic [7:0] link_ma,
  output logic [7:0] link_op,
  // read data pins
  input wire logic [7:0] dq_out,
  input wire logic dq_oe_n
);
  logic [7:0] rd_data;
  logic rd_seen = 1'b0;
  logic cap_ok;

  initial begin
    link_ck = 1'b0;
    link_cs = 1'b0;
    link_we = 1'b0;
    link_ma = 8'h00;
    link_op = 8'h00;
    cap_ok = 1'b0;
  end

  always @(posedge clk) begin
    if (dq_oe_n === 1'b0) begin
      rd_data <= dq_out;
      rd_seen <= 1'b1;
    end else if (link_cs === 1'b1) begin
      // a new command clears the previous read
      rd_seen <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic mr_cmd(input logic we, input logic [7:0] ma, input logic [7:0] op);
    logic [7:0] val;
    val = op;
    if (we && ma == `MA_VTEST) val = 8'h00;
    if (we && ma == `MA_SE && !cap_ok) val = 8'h00;
    @(negedge clk);
    link_cs = 1'b1;
    link_we = we;
    link_ma = ma;
    link_op = val;
    repeat (2) @(negedge clk);
    link_ck = 1'b1;
    repeat (4) @(negedge clk);
    link_ck = 1'b0;
    link_cs = 1'b0;
    // released pins show inverse, not last value
    link_ma = ~ma;
    link_op = ~val;
    repeat (4) @(negedge clk);
  endtask

  task automatic mr_read(input logic [7:0] ma, output logic [7:0] data, output logic ok);
    mr_cmd(1'b0, ma, 8'h00);
    for (int i = 0; i < 16 && !rd_seen; i++) @(posedge clk);
    data = rd_data;
    ok = rd_seen;
    if (ma == `MA_REV) cap_ok = rd_data[0];
    // let the read data window close before the next command
    repeat (8) @(negedge clk);
  endtask
endmodule

// file: dv/dram_mode_register_bank_b_tb_top.sv
// self-checking bench for the mode register bank
`timescale 1ns/1ps
`include "mrb_cfg.svh"
module dram_mode_register_bank_b_tb_top;
  localparam logic [6:0] TB_REV = 7'h15; // arbitrary value
  localparam logic [3:0] TB_DENS = 4'h6;
  logic clk, nrst, zq_to_gnd;
  logic link_ck, link_cs, link_we;
  logic [7:0] link_ma, link_op, dq_out;
  logic dq_oe_n, impedance_default_reset_pulse, cal_default, vref_range, setpoint_active, single_ended_en;
  logic [2:0] dq_term, ca_term;
  logic [5:0] vref_level;
  logic [8:0] vref_tenth_pct;
  int err_total = 0;
  int cmp_count = 0;
  int pulse_cnt = 0;

  dram_mode_register_bank_b #(.REV_CODE(TB_REV), .SE_CAP(1'b1), .DENSITY(TB_DENS)) dut (
    .clk(clk), .nrst(nrst), .link_ck(link_ck), .link_cs(link_cs), .link_we(link_we),
    .link_ma(link_ma), .link_op(link_op), .zq_to_gnd(zq_to_gnd), .dq_out(dq_out),
    .dq_oe_n(dq_oe_n), .impedance_default_reset_pulse(impedance_default_reset_pulse), .cal_default(cal_default),
    .dq_term(dq_term), .ca_term(ca_term), .vref_level(vref_level), .vref_range(vref_range),
    .vref_tenth_pct(vref_tenth_pct), .setpoint_active(setpoint_active),
    .single_ended_en(single_ended_en));

  mr_ctrl_model model (
    .clk(clk), .link_ck(link_ck), .link_cs(link_cs), .link_we(link_we),
    .link_ma(link_ma), .link_op(link_op), .dq_out(dq_out), .dq_oe_n(dq_oe_n));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) if (impedance_default_reset_pulse === 1'b1) pulse_cnt <= pulse_cnt + 1;

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rd(input logic [7:0] ma, input logic [7:0] exp, input string what);
    logic [7:0] d;
    logic ok;
    model.mr_read(ma, d, ok);
    chk(what, {1'b1, exp}, {ok, d});
    chk("dq idle", 9'h100, {dq_oe_n, dq_out});
  endtask

  // write effects land within a few clocks of the link edge
  task automatic wr(input logic [7:0] ma, input logic [7:0] op);
    model.mr_cmd(1'b1, ma, op);
    repeat (4) @(negedge clk);
  endtask

  task automatic do_reset(input logic strap);
    @(negedge clk);
    zq_to_gnd = strap;
    nrst = 1'b0;
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    repeat (8) @(negedge clk);
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_strap;
    do_reset(1'b1);
    chk("cal_default", 9'h001, 9'(cal_default));
    wr(`MA_ZQ, 8'h01);
    chk("pulses", 9'h000, 9'(pulse_cnt));
    $display("test strap done");
  endtask

  task automatic t_reset_vals;
    do_reset(1'b0);
    chk("terms", 9'h000, {3'b000, dq_term, ca_term});
    chk("vref", 9'h04D, {2'b00, vref_range, vref_level});
    chk("tenth", 9'h110, vref_tenth_pct);
    chk("flags", 9'h000, {6'h00, setpoint_active, single_ended_en, cal_default});
    rd(`MA_VREF, 8'h4D, "vref rd");
    $display("test reset done");
  endtask

  task automatic t_ident;
    rd(`MA_REV, {TB_REV, 1'b1}, "rev");
    wr(`MA_REV, 8'h00);
    wr(`MA_CFG, 8'hFF);
    rd(`MA_REV, {TB_REV, 1'b1}, "rev ro");
    rd(`MA_CFG, {2'b00, TB_DENS, 2'b00}, "cfg");
    wr(`MA_VTEST, 8'hA5);
    rd(`MA_VTEST, 8'h00, "vtest");
    $display("test ident done");
  endtask

  task automatic t_cal;
    wr(`MA_ZQ, 8'h01);
    chk("pulses", 9'h001, 9'(pulse_cnt));
    chk("cal_default", 9'h001, 9'(cal_default));
    rd(`MA_ZQ, 8'h00, "zq rd");
    $display("test cal done");
  endtask

  task automatic t_term;
    wr(`MA_FSP, 8'h40);
    wr(`MA_ODT, 8'h65);
    chk("inactive", 9'h000, {2'b00, setpoint_active, dq_term, ca_term});
    rd(`MA_ODT, 8'h65, "odt sp1");
    wr(`MA_FSP, 8'h00);
    rd(`MA_ODT, 8'h00, "odt sp0");
    wr(`MA_FSP, 8'hC0);
    chk("active", {2'b01, 1'b1, 3'h5, 3'h6}, {2'b01, setpoint_active, dq_term, ca_term});
    for (int n = 1; n < 7; n++) begin
      wr(`MA_ODT, {1'b0, 3'(n), 1'b0, 3'(n)});
      chk("codes", {3'b000, 3'(n), 3'(n)}, {3'b000, dq_term, ca_term});
    end
    wr(`MA_ODT, 8'hFF);
    rd(`MA_ODT, 8'h77, "odt rsvd");
    chk("rsvd off", 9'h000, {3'b000, dq_term, ca_term});
    $display("test term done");
  endtask

  task automatic t_vref;
    logic [7:0] c;
    logic [7:0] codes [3] = '{8'h32, 8'hF2, 8'h00};
    for (int i = 0; i < 3; i++) begin
      c = codes[i];
      wr(`MA_VREF, c);
      rd(`MA_VREF, {1'b0, c[6:0]}, "vref rd");
      chk("vref", {2'b00, c[6:0]}, {2'b00, vref_range, vref_level});
      chk("tenth", 9'(c[6] ? 220 : 100) + {1'b0, c[5:0], 2'b00}, vref_tenth_pct);
    end
    wr(`MA_FSP, 8'h00);
    chk("sp0 tenth", 9'h110, vref_tenth_pct);
    wr(`MA_FSP, 8'h40);
    wr(`MA_VREF, 8'h05);
    chk("inactive tenth", 9'h110, vref_tenth_pct);
    $display("test vref done");
  endtask

  task automatic t_se;
    rd(`MA_REV, {TB_REV, 1'b1}, "cap");
    wr(`MA_SE, 8'h01);
    chk("se_en", 9'h001, 9'(single_ended_en));
    wr(`MA_FSP, 8'hC0);
    do_reset(1'b0);
    chk("vref", 9'h04D, {2'b00, vref_range, vref_level});
    chk("se_en rst", 9'h000, 9'(single_ended_en));
    $display("test se done");
  endtask

  initial begin
    nrst = 1'b0;
    zq_to_gnd = 1'b0;
    fork
      begin
        #100000;
        err_total++;
        tally_and_finish();
      end
    join_none
    t_strap();
    t_reset_vals();
    t_ident();
    t_cal();
    t_term();
    t_vref();
    t_se();
    tally_and_finish();
  end
endmodule
